// *** aif_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing constants
// Assumes: 20 MHz system clock; register port with 8-bit addresses
// Notes:   Definitions only
`ifndef AIF_DEFS_SVH
`define AIF_DEFS_SVH

// ****************************************
// Register offsets and register reset value
// ****************************************
`define AIF_OFS_AXIS_EN    8'h10
`define AIF_OFS_PWR_MODE   8'h12
`define AIF_OFS_SLEEP_RATE 8'h13
`define AIF_OFS_OP_MODE    8'h14
`define AIF_OFS_WAKE_TIME  8'h1c
`define AIF_OFS_WAKE_THS   8'h1d
`define AIF_OFS_WAKE_SRC   8'h21
`define AIF_OFS_IRQ_ROUTE  8'h1f
`define AIF_OFS_IRQ_CFG    8'h17
`define AIF_REG_RESET      8'h00

// ****************************************
// Field positions
// ****************************************
`define AIF_THS_SLEEP_ON   6
`define AIF_PWR_HP         2
`define AIF_CFG_IRQ_EN     0
`define AIF_CFG_SLEEP_PIN  3
`define AIF_CFG_FINE       4
`define AIF_ROUTE_WAKE     5
`define AIF_ROUTE_SLEEP    7
`define AIF_SRC_CHANGE     6
`define AIF_SRC_SLEEP      4
`define AIF_SRC_WAKE       3

// ****************************************
// Rate codes and timing
// ****************************************
`define AIF_ODR_SLEEP1     4'h1
`define AIF_ODR_SLEEP2     4'h2
`define AIF_ODR_25HZ       4'h3
`define AIF_CLK_HZ         20000000
`define AIF_INACT_STEP     512
`define AIF_INACT_MIN      16
`define AIF_CHG_SHORT_MS   17
`define AIF_CHG_LONG_MS    37
`define AIF_SLOW_ODR_HZ    50
`define AIF_CHG_SHORT_CYC  (`AIF_CHG_SHORT_MS * (`AIF_CLK_HZ / 1000))
`define AIF_CHG_LONG_CYC   (`AIF_CHG_LONG_MS * (`AIF_CLK_HZ / 1000))
`define AIF_SLOW_PER_CYC   (`AIF_CLK_HZ / `AIF_SLOW_ODR_HZ)

`endif

// *** aif_pkg.sv ***
// Purpose: Types shared by the activity/inactivity block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in aif_defs.svh
package aif_pkg;
  typedef enum logic {AWAKE, ASLEEP} aif_state_t;
  typedef logic [7:0] aif_byte_t;
  typedef logic signed [15:0] aif_sample_t;
endpackage

// *** aif_cmp_if.sv ***
// Purpose: Carrier between the core and the threshold comparator
// Assumes: Combinational comparator
// Notes:   One sample of three axes per transfer
`timescale 1ns/10ps
interface aif_cmp_if;
  import aif_pkg::*;
  aif_sample_t x;
  aif_sample_t y;
  aif_sample_t z;
  logic [5:0]  ths;
  logic        fine;
  logic [2:0]  axis_en;
  logic        over;
  modport cmp  (input x, y, z, ths, fine, axis_en, output over);
  modport user (output x, y, z, ths, fine, axis_en, input over);
endinterface

// *** aif_cmp.sv ***
// Purpose: Magnitude compare of slope samples against the wake threshold
// Assumes: Samples are two's complement, full scale equals 2^15 counts
// Notes:   Purely combinational
`timescale 1ns/10ps
module aif_cmp
  import aif_pkg::*;
(
  aif_cmp_if.cmp bus
);

  // Absolute value, widened so that the most negative code fits
  function automatic logic [16:0] mag(input aif_sample_t v);
    mag = v[15] ? (17'h00000 - {1'b1, v}) : {1'b0, v};
  endfunction

  logic [16:0] thr;

  // ****************************************
  // Threshold scaling and compare
  // ****************************************
  always_comb begin
    // Coarse step is FS/64, fine step FS/256
    thr = bus.fine ? {4'h0, bus.ths, 7'h00} : {2'h0, bus.ths, 9'h000};
    // Sign ignored, same magnitude both ways
    bus.over = (bus.axis_en[0] && mag(bus.x) > thr) ||
               (bus.axis_en[1] && mag(bus.y) > thr) ||
               (bus.axis_en[2] && mag(bus.z) > thr);
  end

endmodule

// *** aif_top.sv ***
// Purpose: Activity/inactivity recognition with sleep rate override
// Assumes: SAMPLE_VALID pulses once per sample at the effective rate
// Notes:   Register port is the internal side of the serial interface
`timescale 1ns/10ps
`include "aif_defs.svh"

// Functional notes
// - Recognition runs only with sleep enable set
// - Sleep switches to selected ultralow-power rate
// - Wake returns to programmed mode and rate
// - Threshold step FS/64, or FS/256 fine
// - Positive and negative samples share threshold
// - Sleep overrides rate, mode register untouched
// - Inactivity time 512 samples per step, 16 default
// - Sleep state bit high throughout inactivity
// - Change flag pulses 17 ms on wake, up to 37 ms on sleep entry
// - Pin shows sleep level or change flag
// - Sleep routing bit required; no latch modes
// - One over-threshold sample restores programmed rate
// - Wake interrupt delayed by wake delay samples
// - Wake flag one sample long, routed by bit
// - Sleep rate select 11 gives 25 Hz
// - Sleep rate 00 reports state, no rate change
module aif_top
  import aif_pkg::*;
#(
  parameter int INACT_STEP    = `AIF_INACT_STEP,
  parameter int INACT_MIN     = `AIF_INACT_MIN,
  parameter int CHG_SHORT_CYC = `AIF_CHG_SHORT_CYC,
  parameter int CHG_LONG_CYC  = `AIF_CHG_LONG_CYC,
  parameter int SLOW_PER_CYC  = `AIF_SLOW_PER_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output      logic [7:0]  REG_RDATA,
  input  wire logic        SAMPLE_VALID,
  input  wire aif_sample_t SLOPE_X,
  input  wire aif_sample_t SLOPE_Y,
  input  wire aif_sample_t SLOPE_Z,
  output      logic [3:0]  EFF_ODR,
  output      logic        ULP_OVERRIDE,
  output      logic        SLEEP_STATE,
  output      logic        INT_PIN
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (INACT_STEP < 1 || INACT_STEP * 15 > 65535 || INACT_MIN < 1 || INACT_MIN > 65535)
    $error("inactivity step or minimum out of range");
  if (CHG_SHORT_CYC < 1 || CHG_LONG_CYC < 1 || SLOW_PER_CYC < 1 ||
      SLOW_PER_CYC + CHG_SHORT_CYC > 1048575 || CHG_LONG_CYC > 1048575)
    $error("change flag timing exceeds the 20-bit timer");

  // ****************************************
  // Register file
  // ****************************************
  aif_byte_t axis_en_reg, axis_en_next;
  aif_byte_t power_mode_reg, power_mode_next;
  aif_byte_t sleep_rate_reg, sleep_rate_next;
  aif_byte_t operating_mode_reg, operating_mode_next;
  aif_byte_t wake_timing_reg, wake_timing_next;
  aif_byte_t wake_threshold_reg, wake_threshold_next;
  aif_byte_t irq_routing_reg, irq_routing_next;
  aif_byte_t irq_config_reg, irq_config_next;
  aif_byte_t rdata_reg, rdata_next;
  aif_state_t  state_reg, state_next;
  logic        wake_flag_reg, wake_flag_next;
  logic [19:0] chg_cnt_reg, chg_cnt_next;

  // Host writes land one edge later; read data is registered
  always_comb begin
    axis_en_next        = axis_en_reg;
    power_mode_next     = power_mode_reg;
    sleep_rate_next     = sleep_rate_reg;
    operating_mode_next = operating_mode_reg;
    wake_timing_next    = wake_timing_reg;
    wake_threshold_next = wake_threshold_reg;
    irq_routing_next    = irq_routing_reg;
    irq_config_next     = irq_config_reg;
    if (REG_WR) begin
      unique case (REG_ADDR)
        `AIF_OFS_AXIS_EN:    axis_en_next        = REG_WDATA;
        `AIF_OFS_PWR_MODE:   power_mode_next     = REG_WDATA;
        `AIF_OFS_SLEEP_RATE: sleep_rate_next     = REG_WDATA;
        `AIF_OFS_OP_MODE:    operating_mode_next = REG_WDATA;
        `AIF_OFS_WAKE_TIME:  wake_timing_next    = REG_WDATA;
        `AIF_OFS_WAKE_THS:   wake_threshold_next = REG_WDATA;
        `AIF_OFS_IRQ_ROUTE:  irq_routing_next    = REG_WDATA;
        `AIF_OFS_IRQ_CFG:    irq_config_next     = REG_WDATA;
        default: ;
      endcase
    end
    unique case (REG_ADDR)
      `AIF_OFS_AXIS_EN:    rdata_next = axis_en_reg;
      `AIF_OFS_PWR_MODE:   rdata_next = power_mode_reg;
      `AIF_OFS_SLEEP_RATE: rdata_next = sleep_rate_reg;
      `AIF_OFS_OP_MODE:    rdata_next = operating_mode_reg;
      `AIF_OFS_WAKE_TIME:  rdata_next = wake_timing_reg;
      `AIF_OFS_WAKE_THS:   rdata_next = wake_threshold_reg;
      `AIF_OFS_IRQ_ROUTE:  rdata_next = irq_routing_reg;
      `AIF_OFS_IRQ_CFG:    rdata_next = irq_config_reg;
      `AIF_OFS_WAKE_SRC:   rdata_next = {1'b0, chg_cnt_reg != 20'h00000, 1'b0,
                                         state_reg == ASLEEP, wake_flag_reg, 3'h0};
      default:             rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      axis_en_reg        <= `AIF_REG_RESET;
      power_mode_reg     <= `AIF_REG_RESET;
      sleep_rate_reg     <= `AIF_REG_RESET;
      operating_mode_reg <= `AIF_REG_RESET;
      wake_timing_reg    <= `AIF_REG_RESET;
      wake_threshold_reg <= `AIF_REG_RESET;
      irq_routing_reg    <= `AIF_REG_RESET;
      irq_config_reg     <= `AIF_REG_RESET;
      rdata_reg          <= 8'h00;
    end else begin
      axis_en_reg        <= axis_en_next;
      power_mode_reg     <= power_mode_next;
      sleep_rate_reg     <= sleep_rate_next;
      operating_mode_reg <= operating_mode_next;
      wake_timing_reg    <= wake_timing_next;
      wake_threshold_reg <= wake_threshold_next;
      irq_routing_reg    <= irq_routing_next;
      irq_config_reg     <= irq_config_next;
      rdata_reg          <= rdata_next;
    end
  end

  // ****************************************
  // Threshold comparator
  // ****************************************
  aif_cmp_if cmp_bus ();

  assign cmp_bus.x       = SLOPE_X;
  assign cmp_bus.y       = SLOPE_Y;
  assign cmp_bus.z       = SLOPE_Z;
  assign cmp_bus.ths     = wake_threshold_reg[5:0];
  assign cmp_bus.fine    = irq_config_reg[`AIF_CFG_FINE];
  assign cmp_bus.axis_en = axis_en_reg[2:0];

  aif_cmp u_cmp (
    .bus (cmp_bus.cmp)
  );

  // Sleep rate select mapped to a rate code
  function automatic logic [3:0] sleep_odr(input logic [1:0] sel);
    unique case (sel)
      2'h1:    sleep_odr = `AIF_ODR_SLEEP1;
      2'h2:    sleep_odr = `AIF_ODR_SLEEP2;
      2'h3:    sleep_odr = `AIF_ODR_25HZ;
      default: sleep_odr = 4'h0;
    endcase
  endfunction

  // ****************************************
  // Recognition state
  // ****************************************
  logic [15:0] inact_cnt_reg, inact_cnt_next;
  logic [1:0]  dly_cnt_reg, dly_cnt_next;
  logic        dly_pend_reg, dly_pend_next;
  logic [19:0] per_cnt_reg, per_cnt_next;
  logic [19:0] per_meas_reg, per_meas_next;
  logic [3:0]  odr_reg, odr_next;
  logic        ulp_reg, ulp_next;
  logic        int_reg, int_next;
  logic        enabled;
  logic        tick;
  logic [15:0] target;
  logic [1:0]  rate_sel;

  // One evaluation per sample while enabled
  always_comb begin
    enabled  = wake_threshold_reg[`AIF_THS_SLEEP_ON] && !power_mode_reg[`AIF_PWR_HP];
    tick     = enabled && SAMPLE_VALID;
    rate_sel = sleep_rate_reg[7:6];
    target   = (wake_timing_reg[3:0] == 4'h0) ? 16'(INACT_MIN)
               : 16'(int'(wake_timing_reg[3:0]) * INACT_STEP);
    state_next     = state_reg;
    inact_cnt_next = inact_cnt_reg;
    dly_cnt_next   = dly_cnt_reg;
    dly_pend_next  = dly_pend_reg;
    wake_flag_next = wake_flag_reg;
    chg_cnt_next   = (chg_cnt_reg != 20'h00000) ? chg_cnt_reg - 20'h00001 : chg_cnt_reg;
    per_cnt_next   = (per_cnt_reg != 20'hfffff) ? per_cnt_reg + 20'h00001 : per_cnt_reg;
    per_meas_next  = per_meas_reg;
    // Active sample spacing, measured only at the programmed rate
    if (SAMPLE_VALID) begin
      per_cnt_next = 20'h00000;
      if (state_reg == AWAKE)
        per_meas_next = per_cnt_reg;
    end
    // Wake flag lasts one sample period, then clears itself
    if (SAMPLE_VALID)
      wake_flag_next = 1'b0;
    if (!enabled) begin
      // Disabling drops the override at once
      state_next     = AWAKE;
      inact_cnt_next = 16'h0000;
      dly_pend_next  = 1'b0;
    end else if (tick) begin
      if (dly_pend_reg) begin
        // Delayed wake interrupt, one step per sample
        dly_cnt_next = dly_cnt_reg - 2'h1;
        if (dly_cnt_reg == 2'h1) begin
          dly_pend_next  = 1'b0;
          wake_flag_next = 1'b1;
        end
      end else if (cmp_bus.over) begin
        if (wake_timing_reg[6:5] == 2'h0)
          wake_flag_next = 1'b1;
        else begin
          dly_pend_next = 1'b1;
          dly_cnt_next  = wake_timing_reg[6:5];
        end
      end
      if (cmp_bus.over) begin
        inact_cnt_next = 16'h0000;
        if (state_reg == ASLEEP) begin
          // One over-threshold sample wakes
          state_next   = AWAKE;
          chg_cnt_next = 20'(CHG_SHORT_CYC);
        end
      end else if (state_reg == AWAKE) begin
        if (inact_cnt_reg + 16'h0001 >= target) begin
          state_next     = ASLEEP;
          inact_cnt_next = 16'h0000;
          // Slow active rate gets the long hold
          chg_cnt_next = (per_meas_reg > 20'(SLOW_PER_CYC)) ? 20'(CHG_LONG_CYC)
                         : per_meas_reg + 20'(CHG_SHORT_CYC);
        end else
          inact_cnt_next = inact_cnt_reg + 16'h0001;
      end
    end
    // Override only the effective rate, never the stored mode
    if (state_next == ASLEEP && rate_sel != 2'h0) begin
      odr_next = sleep_odr(rate_sel);
      ulp_next = 1'b1;
    end else begin
      odr_next = operating_mode_reg[7:4];
      ulp_next = 1'b0;
    end
    // No latch mode applies to sleep signals; pin shows sleep level or change flag
    int_next = irq_config_reg[`AIF_CFG_IRQ_EN] &&
               ((irq_routing_reg[`AIF_ROUTE_WAKE] && wake_flag_next) ||
                (irq_routing_reg[`AIF_ROUTE_SLEEP] &&
                 (irq_config_reg[`AIF_CFG_SLEEP_PIN] ? state_next == ASLEEP
                                                     : chg_cnt_next != 20'h00000)));
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg     <= AWAKE;
      inact_cnt_reg <= 16'h0000;
      dly_cnt_reg   <= 2'h0;
      dly_pend_reg  <= 1'b0;
      wake_flag_reg <= 1'b0;
      chg_cnt_reg   <= 20'h00000;
      per_cnt_reg   <= 20'h00000;
      per_meas_reg  <= 20'h00000;
      odr_reg       <= 4'h0;
      ulp_reg       <= 1'b0;
      int_reg       <= 1'b0;
    end else begin
      state_reg     <= state_next;
      inact_cnt_reg <= inact_cnt_next;
      dly_cnt_reg   <= dly_cnt_next;
      dly_pend_reg  <= dly_pend_next;
      wake_flag_reg <= wake_flag_next;
      chg_cnt_reg   <= chg_cnt_next;
      per_cnt_reg   <= per_cnt_next;
      per_meas_reg  <= per_meas_next;
      odr_reg       <= odr_next;
      ulp_reg       <= ulp_next;
      int_reg       <= int_next;
    end
  end

  // Every output straight from a flop; sleep bit tracks state
  assign REG_RDATA    = rdata_reg;
  assign EFF_ODR      = odr_reg;
  assign ULP_OVERRIDE = ulp_reg;
  assign SLEEP_STATE  = (state_reg == ASLEEP);
  assign INT_PIN      = int_reg;

  // ****************************************
  // Checks
  // ****************************************
  chk_disable_forces_awake: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !enabled |=> state_reg == AWAKE)
    else $error("recognition active while disabled");

  chk_sleep_rate_code: assert property (@(posedge CLOCK) disable iff (!RST_N)
    state_reg == ASLEEP && $past(sleep_rate_reg[7:6]) == 2'h3 |-> odr_reg == `AIF_ODR_25HZ)
    else $error("sleep rate 11 not applied");

  chk_mode_reg_kept: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !REG_WR ##1 $rose(state_reg == ASLEEP) |-> $stable(operating_mode_reg))
    else $error("mode register changed by sleep entry");

  chk_wake_restores: assert property (@(posedge CLOCK) disable iff (!RST_N)
    tick && cmp_bus.over && state_reg == ASLEEP |=> state_reg == AWAKE
      && odr_reg == operating_mode_reg[7:4] && !ulp_reg)
    else $error("over-threshold sample did not wake");

  chk_stationary_no_rate: assert property (@(posedge CLOCK) disable iff (!RST_N)
    sleep_rate_reg[7:6] == 2'h0 && !$past(REG_WR) |-> !ulp_reg && odr_reg == operating_mode_reg[7:4])
    else $error("rate changed in stationary mode");

  chk_wake_no_delay: assert property (@(posedge CLOCK) disable iff (!RST_N)
    tick && !dly_pend_reg && cmp_bus.over && wake_timing_reg[6:5] == 2'h0 |=> wake_flag_reg)
    else $error("undelayed wake flag late");

  chk_wake_one_sample: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wake_flag_reg && SAMPLE_VALID && !(tick && (dly_pend_reg || cmp_bus.over)) |=> !wake_flag_reg)
    else $error("wake flag outlived one sample");

  chk_change_on_wake: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $fell(state_reg == ASLEEP) && enabled |-> chg_cnt_reg == 20'(CHG_SHORT_CYC))
    else $error("change flag hold wrong on wake");

  chk_pin_sleep_level: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ##1 irq_config_reg == 8'h09 && irq_routing_reg == 8'h80 && $stable(irq_config_reg)
      && $stable(irq_routing_reg) && $stable(wake_threshold_reg) && $stable(power_mode_reg)
      |-> INT_PIN == SLEEP_STATE)
    else $error("pin does not follow sleep level");

endmodule

// *** aif_host.sv ***
// Purpose: Host processor model on the register port of the block
// Assumes: One write or one read at a time, requests change after rising edges
// Notes:   rd_v marks the cycle whose address the read data will answer
`timescale 1ns/10ps
module aif_host (
  input  wire logic       clock,
  output      logic       reg_wr,
  output      logic [7:0] reg_addr,
  output      logic [7:0] reg_wdata,
  output      logic       rd_v
);
  // ****************************************
  // Idle bus
  // ****************************************
  initial begin
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    rd_v      = 1'b0;
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  // One-cycle strobe, then a cycle of rest
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // Address held two edges so the registered data can land
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    rd_v     <= 1'b1;
    @(posedge clock);
    rd_v     <= 1'b0;
    @(posedge clock);
  endtask

  // Power-down first, since the enable must not land while running
  task automatic cfg(input logic [7:0] tim, input logic [7:0] route);
    wr(8'h14, 8'h00);
    wr(8'h12, 8'h00); // Low-power mode
    wr(8'h13, 8'hc0);
    wr(8'h10, 8'h17);
    wr(8'h1c, tim);
    wr(8'h1d, 8'h42);
    wr(8'h1f, route);
    wr(8'h17, 8'h01);
    wr(8'h14, 8'h90);
  endtask
endmodule

// *** aif_top_bench.sv ***
// Purpose: Self-checking bench for the activity/inactivity block
// Assumes: Shortened counts: 4 samples per step, 2 minimum, short timers
// Notes:   Output byte is {sleep, override, pin, 0, rate code}
`timescale 1ns/10ps
module aif_top_bench;
  import aif_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr;
  logic        rd_v;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        smp_v = 1'b0;
  aif_sample_t sx = '0;
  aif_sample_t sy = '0;
  aif_sample_t sz = '0;
  logic [3:0]  eff_odr;
  logic        ulp;
  logic        slp;
  logic        int_pin;
  int          errors = 0;
  int          num_checks = 0;
  logic [7:0]  q_out[$];
  logic [7:0]  q_reg[$];

  // 20 MHz clock
  always #25 clock = ~clock;

  aif_top #(.INACT_STEP(4), .INACT_MIN(2), .CHG_SHORT_CYC(20), .CHG_LONG_CYC(40),
            .SLOW_PER_CYC(30)) dut_u (
    .CLOCK(clock), .RST_N(rst_n), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SAMPLE_VALID(smp_v),
    .SLOPE_X(sx), .SLOPE_Y(sy), .SLOPE_Z(sz), .EFF_ODR(eff_odr),
    .ULP_OVERRIDE(ulp), .SLEEP_STATE(slp), .INT_PIN(int_pin)
  );

  aif_host host_u (
    .clock(clock), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .rd_v(rd_v)
  );

  // ****************************************
  // Compares and verdict
  // ****************************************
  task automatic cmp_out(input logic [7:0] exp);
    logic [7:0] got;
    got = {slp, ulp, int_pin, 1'b0, eff_odr};
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t outputs %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_reg(input logic [7:0] exp);
    num_checks++;
    if (reg_rdata !== exp) begin
      errors++;
      $display("[ERR] %0t read %h expected %h", $time, reg_rdata, exp);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Outputs follow the new state at the sample edge itself
  always @(posedge clock) begin
    if (smp_v === 1'b1 && rst_n === 1'b1) begin
      #1;
      cmp_out(q_out.pop_front());
    end
  end

  // Read data is registered, so it answers one edge later
  always @(posedge clock) begin
    if (rd_v === 1'b1) begin
      @(posedge clock);
      #1;
      cmp_reg(q_reg.pop_front());
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  // Quiet values reach the threshold but never pass it
  function automatic aif_sample_t rq();
    return 16'(int'($urandom_range(2048)) - 1024);
  endfunction

  task automatic smp(input aif_sample_t x, y, z, input logic [7:0] exp);
    q_out.push_back(exp);
    @(posedge clock);
    smp_v <= 1'b1;
    sx    <= x;
    sy    <= y;
    sz    <= z;
    @(posedge clock);
    smp_v <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic quiet(input int n, input logic [7:0] exp);
    repeat (n) smp(rq(), rq(), rq(), exp);
  endtask

  // One axis over threshold, random sign
  task automatic over(input logic [7:0] exp);
    aif_sample_t v;
    int          a;
    v = 16'(1025 + int'($urandom_range(999)));
    if ($urandom_range(1) == 1)
      v = -v;
    a = int'($urandom_range(2));
    smp(a == 0 ? v : rq(), a == 1 ? v : rq(), a == 2 ? v : rq(), exp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    q_reg.push_back(exp);
    host_u.rd(a);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("[ERR] %0t run limit reached", $time);
    summarize();
  end

  initial begin
    void'($urandom(67819));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h17, 8'h00);
    rd(8'h55, 8'h00);
    host_u.wr(8'h21, 8'hff);
    rd(8'h21, 8'h00);
    host_u.cfg(8'h41, 8'h20);
    rd(8'h17, 8'h01);
    quiet(3, 8'h09);
    quiet(1, 8'hc3);
    rd(8'h14, 8'h90);
    rd(8'h21, 8'h50);
    over(8'h09);
    quiet(1, 8'h09);
    quiet(1, 8'h29);
    quiet(1, 8'h09);
    quiet(1, 8'hc3);
    // Every sleep rate code, zero delay on the wake flag
    host_u.wr(8'h1c, 8'h01);
    for (int r = 0; r < 4; r++) begin
      host_u.wr(8'h13, 8'(r << 6));
      over(8'h29);
      quiet(3, 8'h09);
      quiet(1, r == 0 ? 8'h89 : 8'hc0 | 8'(r));
    end
    host_u.wr(8'h17, 8'h11);
    smp(16'sd256, 0, 0, 8'hc3);
    smp(0, 0, -16'sd257, 8'h29);
    // Sleep level, then change flag on the pin
    host_u.wr(8'h1f, 8'h80);
    host_u.wr(8'h17, 8'h09);
    quiet(3, 8'h09);
    quiet(1, 8'he3);
    over(8'h09);
    host_u.wr(8'h17, 8'h01);
    repeat (30) @(posedge clock);
    quiet(3, 8'h09);
    quiet(1, 8'he3);
    repeat (60) @(posedge clock);
    quiet(1, 8'hc3);
    // Wake hold on the pin, then the long hold after a slow sample gap
    over(8'h29);
    quiet(2, 8'h29);
    repeat (30) @(posedge clock);
    quiet(1, 8'h09);
    quiet(1, 8'he3);
    repeat (40) @(posedge clock);
    quiet(1, 8'hc3);
    host_u.wr(8'h1f, 8'h00);
    host_u.wr(8'h1d, 8'h02);
    quiet(6, 8'h09);
    summarize();
  end
endmodule
